// ==== rrcc_pkg.sv ====
package rrcc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYMBOL_NS = 16000;
    localparam int SYMBOL_CYCLES = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AVG_WINDOW_US = 128;
    localparam int AVG_SYMBOLS = 8;
    localparam int CORR_SYMBOLS = 8;
    localparam int CCA_VALID_SYMBOLS = 8;
    localparam logic [11:0] BASE_CHANNEL_FREQUENCY_WORD_MHZ = 12'h800;
    localparam logic [11:0] RX_IF_MHZ = 12'h002;

    localparam logic [7:0] ADDR_RSSI = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h01;
    localparam logic [7:0] ADDR_MODEM0_HIGH = 8'h02;
    localparam logic [7:0] ADDR_MODEM0_LOW = 8'h03;
    localparam logic [7:0] ADDR_MODEM1_LOW = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_FLAGS = 8'h06;
    localparam logic [7:0] ADDR_MASK = 8'h07;
    localparam logic [7:0] ADDR_SYNTH_HIGH = 8'h08;
    localparam logic [7:0] ADDR_SYNTH_LOW = 8'h09;
    localparam logic [7:0] ADDR_TX_POWER = 8'h0A;
    localparam logic [7:0] ADDR_DAC_HIGH = 8'h0B;
    localparam logic [7:0] ADDR_DAC_LOW = 8'h0C;
    localparam logic [7:0] ADDR_COMMAND = 8'h0D;
    localparam logic [7:0] ADDR_GAIN_LOW = 8'h0E;
    localparam logic [7:0] ADDR_GAIN_HIGH = 8'h0F;
    localparam logic [7:0] ADDR_CORR = 8'h10;

    localparam int HYST_LSB = 0;
    localparam int CLEAR_ASSESS_SELECT_LSB = 6;
    localparam int AUTO_CHECKSUM_ENABLE_BIT = 5;
    localparam int TX_MODE_LSB = 2;

    localparam logic [7:0] CMD_RX_ON = 8'h01;
    localparam logic [7:0] CMD_TX_ON = 8'h02;
    localparam logic [7:0] CMD_TX_IF_CLEAR = 8'h03;
    localparam logic [7:0] CMD_RF_OFF = 8'h04;
    localparam logic [7:0] CMD_ACK = 8'h05;

    localparam logic [1:0] CCA_ENERGY = 2'h1;
    localparam logic [1:0] CCA_NO_FRAME = 2'h2;
    localparam logic [1:0] CCA_BOTH = 2'h3;
    localparam logic [1:0] TX_MODE_DAC_TEST = 2'h2;

    localparam logic [7:0] RST_THRESH = 8'hE0;
    localparam logic [2:0] RST_HYST = 3'h2;
    localparam logic [1:0] RST_CLEAR_ASSESS_SELECT = 2'h3;
    localparam logic [7:0] RST_TX_POWER = 8'hFF;
    localparam logic [7:0] RST_GAIN_LOW = 8'h00;
    localparam logic [7:0] RST_GAIN_HIGH = 8'h00;

    localparam int FLAG_CLEAR = 0;
    localparam int FLAG_CORR = 1;
    localparam int FLAG_APPEND = 2;
    localparam int FLAG_TX_START = 3;

    typedef enum logic [2:0] {
        RS_IDLE, RS_RX_CAL, RS_RX, RS_TX_CAL, RS_TX, RS_ACK_CAL, RS_ACK
    } rrcc_rf_state_t;

    typedef struct packed {
        logic valid;
        logic [6:0] corr;
        logic [7:0] rssi;
        logic crc_ok;
    } rrcc_append_t;

    typedef struct packed {
        rrcc_rf_state_t rstate;
        logic [15:0] cal_cnt;
        logic [10:0] sym_cnt;
        logic [3:0] rx_syms;
        logic [7:0][7:0] hist;
        logic [2:0] hist_ptr;
        logic [7:0] rssi;
        logic energy_clear;
        logic clear;
        logic [9:0] corr_sum;
        logic [3:0] corr_n;
        logic [6:0] corr_val;
        logic [7:0] thresh;
        logic [2:0] hyst;
        logic [1:0] clear_assess_select;
        logic auto_checksum_enable;
        logic [1:0] tx_mode;
        logic [9:0] channel_frequency_word;
        logic [7:0] power;
        logic [15:0] dac;
        logic [7:0] gain_low;
        logic [7:0] gain_high;
        logic [3:0] flags;
        logic [3:0] mask;
        logic [7:0] rdata;
        logic irq;
        logic sw_pin;
        logic cal_active;
        logic [11:0] lo_mhz;
        logic dac_override;
        rrcc_append_t app;
    } rrcc_state_t;
endpackage

// ==== rrcc_radio_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// Function
// R1: Signal strength readable as 8-bit signed two's complement value.
// R2: Signal strength is always an average over 8 symbol periods; the code counts empty slots after reset as zero.
// R3: Per packet, average correlation of first eight symbols after delimiter, 7 bits.
// R4: With auto checksum on, append correlation, strength and CRC result per frame.
// R5: Software scales correlation into link quality limited to 0-255.
// R6: Assessment from strength versus threshold, valid after 8 receive symbols.
// R7: Threshold in 1 dB steps; separate hysteresis field for the assessment.
// R8: Mode 01 energy, 10 no frame, 11 both, 00 reserved.
// R9: Assessment is an active-high status bit that also sets its interrupt flag.
// R10: Transmit-if-clear starts only when clear; transmitting status shows the result.
// R11: 10-bit frequency word over two registers; carrier is 2048 MHz plus word.
// R12: Receive 2 MHz offset applied automatically; same word serves both directions.
// R13: Software writes 357 + 5*(k-11) for standard channel k.
// R14: Oscillator calibration whenever receive, transmit or acknowledge transmit starts.
// R15: Output power taken from power register, 0xFF full down to 0x03.
// R16: Switch supply pin low in receive, high in transmit.
// R17: Software resets and waits for stable crystal before transmit tests.
// R18: Test mode 2 with DAC word and transmit-on holds DACs static.
// R19: Software leaves gain loop registers at their reset values.
module rrcc_radio_ctrl #(
    parameter int CAL_CYCLES = 1200
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] energy_level,
    input wire logic sfd_detect,
    input wire logic corr_strobe,
    input wire logic [6:0] corr_sample,
    input wire logic frame_active,
    input wire logic frame_end,
    input wire logic crc_ok,
    input wire logic tx_done,
    output logic irq,
    output logic antenna_switch_supply_pin,
    output logic synth_calibrate,
    output logic [11:0] lo_channel_frequency_word_mhz,
    output logic [7:0] pa_power_code,
    output logic dac_override,
    output logic [15:0] dac_static_word,
    output logic [7:0] gain_loop_low,
    output logic [7:0] gain_loop_high,
    output rrcc_pkg::rrcc_append_t frame_append
);
    rrcc_pkg::rrcc_state_t s;
    rrcc_pkg::rrcc_state_t next_s;

    function automatic logic is_tx(input rrcc_pkg::rrcc_rf_state_t st);
        is_tx = (st == rrcc_pkg::RS_TX_CAL) || (st == rrcc_pkg::RS_TX)
            || (st == rrcc_pkg::RS_ACK_CAL) || (st == rrcc_pkg::RS_ACK);
    endfunction

    function automatic logic is_cal(input rrcc_pkg::rrcc_rf_state_t st);
        is_cal = (st == rrcc_pkg::RS_RX_CAL) || (st == rrcc_pkg::RS_TX_CAL)
            || (st == rrcc_pkg::RS_ACK_CAL);
    endfunction

    logic sym_tick;
    logic wr_cmd;
    assign sym_tick = (s.sym_cnt == 11'(rrcc_pkg::SYMBOL_CYCLES - 1));
    assign wr_cmd = reg_wr && (reg_addr == rrcc_pkg::ADDR_COMMAND);

    always_comb begin
        logic signed [10:0] sum;
        logic signed [8:0] low_thr;
        logic energy_ok;
        logic assess;
        logic [3:0] set_f;
        logic [3:0] clr_f;
        logic [9:0] csum;
        sum = '0;
        low_thr = '0;
        energy_ok = 1'b0;
        assess = 1'b0;
        set_f = '0;
        clr_f = '0;
        csum = '0;
        next_s = s;

        // Symbol timebase and averaging window
        next_s.sym_cnt = sym_tick ? '0 : s.sym_cnt + 11'h001;
        if (sym_tick) begin
            next_s.hist[s.hist_ptr] = energy_level; // R2
            next_s.hist_ptr = s.hist_ptr + 3'h1;
        end
        for (int i = 0; i < rrcc_pkg::AVG_SYMBOLS; i++) begin
            sum = sum + 11'($signed(next_s.hist[i])); // R2
        end
        next_s.rssi = 8'(sum >>> 3); // R1

        // Assessment; hysteresis only delays the busy-to-clear transition
        low_thr = $signed({s.thresh[7], s.thresh}) - $signed({6'h00, s.hyst}); // R7
        if (s.energy_clear) begin
            energy_ok = $signed(s.rssi) < $signed(s.thresh); // R7
        end else begin
            energy_ok = $signed({s.rssi[7], s.rssi}) < low_thr;
        end
        next_s.energy_clear = energy_ok;
        case (s.clear_assess_select) // R8
            rrcc_pkg::CCA_ENERGY: assess = energy_ok;
            rrcc_pkg::CCA_NO_FRAME: assess = !frame_active;
            rrcc_pkg::CCA_BOTH: assess = energy_ok && !frame_active;
            default: assess = 1'b0;
        endcase
        if (s.rstate != rrcc_pkg::RS_RX) begin
            next_s.rx_syms = '0;
        end else if (sym_tick && s.rx_syms != 4'(rrcc_pkg::CCA_VALID_SYMBOLS)) begin
            next_s.rx_syms = s.rx_syms + 4'h1;
        end
        next_s.clear = assess && (s.rx_syms == 4'(rrcc_pkg::CCA_VALID_SYMBOLS)); // R6
        set_f[rrcc_pkg::FLAG_CLEAR] = s.clear; // R9

        // Correlation averaging over first symbols after the delimiter
        if (sfd_detect) begin
            next_s.corr_sum = '0;
            next_s.corr_n = '0;
        end else if (corr_strobe && s.corr_n != 4'(rrcc_pkg::CORR_SYMBOLS)) begin
            csum = s.corr_sum + {3'h0, corr_sample};
            next_s.corr_sum = csum;
            next_s.corr_n = s.corr_n + 4'h1;
            if (s.corr_n == 4'(rrcc_pkg::CORR_SYMBOLS - 1)) begin
                next_s.corr_val = csum[9:3]; // R3
                set_f[rrcc_pkg::FLAG_CORR] = 1'b1;
            end
        end
        next_s.app.valid = 1'b0;
        if (frame_end && s.auto_checksum_enable) begin
            next_s.app.valid = 1'b1; // R4
            next_s.app.corr = s.corr_val;
            next_s.app.rssi = s.rssi;
            next_s.app.crc_ok = crc_ok;
            set_f[rrcc_pkg::FLAG_APPEND] = 1'b1;
        end

        // Radio state with calibrate states ahead of every enable
        next_s.cal_cnt = is_cal(s.rstate) ? s.cal_cnt + 16'h0001 : '0;
        case (s.rstate)
            rrcc_pkg::RS_RX_CAL, rrcc_pkg::RS_TX_CAL, rrcc_pkg::RS_ACK_CAL: begin
                if (s.cal_cnt == 16'(CAL_CYCLES - 1)) begin
                    if (s.rstate == rrcc_pkg::RS_RX_CAL) begin
                        next_s.rstate = rrcc_pkg::RS_RX;
                    end else if (s.rstate == rrcc_pkg::RS_TX_CAL) begin
                        next_s.rstate = rrcc_pkg::RS_TX;
                    end else begin
                        next_s.rstate = rrcc_pkg::RS_ACK;
                    end
                end
            end
            rrcc_pkg::RS_TX, rrcc_pkg::RS_ACK: begin
                if (tx_done) begin
                    next_s.rstate = rrcc_pkg::RS_RX_CAL; // R14
                end
            end
            default: begin
            end
        endcase
        if (wr_cmd) begin
            case (reg_wdata)
                rrcc_pkg::CMD_RX_ON: begin
                    if (s.rstate == rrcc_pkg::RS_IDLE) begin
                        next_s.rstate = rrcc_pkg::RS_RX_CAL; // R14
                    end
                end
                rrcc_pkg::CMD_TX_ON: begin
                    if (!is_tx(s.rstate)) begin
                        next_s.rstate = rrcc_pkg::RS_TX_CAL; // R14
                        set_f[rrcc_pkg::FLAG_TX_START] = 1'b1;
                    end
                end
                rrcc_pkg::CMD_TX_IF_CLEAR: begin
                    if (s.rstate == rrcc_pkg::RS_RX && s.clear) begin
                        next_s.rstate = rrcc_pkg::RS_TX_CAL; // R10
                        set_f[rrcc_pkg::FLAG_TX_START] = 1'b1;
                    end
                end
                rrcc_pkg::CMD_ACK: begin
                    if (s.rstate == rrcc_pkg::RS_RX) begin
                        next_s.rstate = rrcc_pkg::RS_ACK_CAL; // R14
                    end
                end
                rrcc_pkg::CMD_RF_OFF: next_s.rstate = rrcc_pkg::RS_IDLE;
                default: begin
                end
            endcase
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                rrcc_pkg::ADDR_THRESH: next_s.thresh = reg_wdata; // R7
                rrcc_pkg::ADDR_MODEM0_HIGH: next_s.hyst = reg_wdata[rrcc_pkg::HYST_LSB +: 3];
                rrcc_pkg::ADDR_MODEM0_LOW: begin
                    next_s.clear_assess_select = reg_wdata[rrcc_pkg::CLEAR_ASSESS_SELECT_LSB +: 2];
                    next_s.auto_checksum_enable = reg_wdata[rrcc_pkg::AUTO_CHECKSUM_ENABLE_BIT];
                end
                rrcc_pkg::ADDR_MODEM1_LOW: next_s.tx_mode = reg_wdata[rrcc_pkg::TX_MODE_LSB +: 2];
                rrcc_pkg::ADDR_FLAGS: clr_f = reg_wdata[3:0];
                rrcc_pkg::ADDR_MASK: next_s.mask = reg_wdata[3:0];
                rrcc_pkg::ADDR_SYNTH_HIGH: next_s.channel_frequency_word[9:8] = reg_wdata[1:0]; // R11
                rrcc_pkg::ADDR_SYNTH_LOW: next_s.channel_frequency_word[7:0] = reg_wdata; // R11
                rrcc_pkg::ADDR_TX_POWER: next_s.power = reg_wdata; // R15
                rrcc_pkg::ADDR_DAC_HIGH: next_s.dac[15:8] = reg_wdata;
                rrcc_pkg::ADDR_DAC_LOW: next_s.dac[7:0] = reg_wdata;
                rrcc_pkg::ADDR_GAIN_LOW: next_s.gain_low = reg_wdata;
                rrcc_pkg::ADDR_GAIN_HIGH: next_s.gain_high = reg_wdata;
                default: begin
                end
            endcase
        end
        // A new event beats a clear in the same cycle
        next_s.flags = (s.flags & ~clr_f) | set_f;
        next_s.irq = |(next_s.flags & next_s.mask);

        // Register reads, data valid only in the cycle after the strobe
        next_s.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                rrcc_pkg::ADDR_RSSI: next_s.rdata = s.rssi; // R1
                rrcc_pkg::ADDR_THRESH: next_s.rdata = s.thresh;
                rrcc_pkg::ADDR_MODEM0_HIGH: next_s.rdata = {5'h00, s.hyst};
                rrcc_pkg::ADDR_MODEM0_LOW: next_s.rdata = {s.clear_assess_select, s.auto_checksum_enable, 5'h00};
                rrcc_pkg::ADDR_MODEM1_LOW: next_s.rdata = {4'h0, s.tx_mode, 2'h0};
                rrcc_pkg::ADDR_STATUS:
                    next_s.rdata = {5'h00, s.cal_active, is_tx(s.rstate), s.clear}; // R9 R10
                rrcc_pkg::ADDR_FLAGS: next_s.rdata = {4'h0, s.flags};
                rrcc_pkg::ADDR_MASK: next_s.rdata = {4'h0, s.mask};
                rrcc_pkg::ADDR_SYNTH_HIGH: next_s.rdata = {6'h00, s.channel_frequency_word[9:8]};
                rrcc_pkg::ADDR_SYNTH_LOW: next_s.rdata = s.channel_frequency_word[7:0];
                rrcc_pkg::ADDR_TX_POWER: next_s.rdata = s.power;
                rrcc_pkg::ADDR_DAC_HIGH: next_s.rdata = s.dac[15:8];
                rrcc_pkg::ADDR_DAC_LOW: next_s.rdata = s.dac[7:0];
                rrcc_pkg::ADDR_GAIN_LOW: next_s.rdata = s.gain_low;
                rrcc_pkg::ADDR_GAIN_HIGH: next_s.rdata = s.gain_high;
                rrcc_pkg::ADDR_CORR: next_s.rdata = {1'b0, s.corr_val}; // R3
                default: next_s.rdata = '0;
            endcase
        end

        // Outputs follow the next state so they come straight from flops
        next_s.sw_pin = is_tx(next_s.rstate); // R16
        next_s.cal_active = is_cal(next_s.rstate); // R14
        next_s.lo_mhz = rrcc_pkg::BASE_CHANNEL_FREQUENCY_WORD_MHZ + {2'h0, next_s.channel_frequency_word}; // R11
        if (!is_tx(next_s.rstate)) begin
            next_s.lo_mhz = next_s.lo_mhz - rrcc_pkg::RX_IF_MHZ; // R12
        end
        next_s.dac_override = (next_s.rstate == rrcc_pkg::RS_TX)
            && (next_s.tx_mode == rrcc_pkg::TX_MODE_DAC_TEST); // R18
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s <= '0;
            s.rstate <= rrcc_pkg::RS_IDLE;
            s.thresh <= rrcc_pkg::RST_THRESH;
            s.hyst <= rrcc_pkg::RST_HYST;
            s.clear_assess_select <= rrcc_pkg::RST_CLEAR_ASSESS_SELECT;
            s.power <= rrcc_pkg::RST_TX_POWER;
            s.gain_low <= rrcc_pkg::RST_GAIN_LOW;
            s.gain_high <= rrcc_pkg::RST_GAIN_HIGH;
            s.lo_mhz <= rrcc_pkg::BASE_CHANNEL_FREQUENCY_WORD_MHZ - rrcc_pkg::RX_IF_MHZ;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign irq = s.irq;
    assign antenna_switch_supply_pin = s.sw_pin;
    assign synth_calibrate = s.cal_active;
    assign lo_channel_frequency_word_mhz = s.lo_mhz;
    assign pa_power_code = s.power;
    assign dac_override = s.dac_override;
    assign dac_static_word = s.dac;
    assign gain_loop_low = s.gain_low;
    assign gain_loop_high = s.gain_high;
    assign frame_append = s.app;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    property p_rssi_read;
        reg_rd && reg_addr == rrcc_pkg::ADDR_RSSI |=> reg_rdata == $past(s.rssi);
    endproperty
    a_rssi_read: assert property (p_rssi_read) else $error("rssi read mismatch"); // R1

    property p_cca_early;
        s.rx_syms != 4'(rrcc_pkg::CCA_VALID_SYMBOLS) |=> !s.clear;
    endproperty
    a_cca_early: assert property (p_cca_early) else $error("clear before valid"); // R6

    property p_cca_reserved;
        s.clear_assess_select == 2'h0 |=> !s.clear;
    endproperty
    a_cca_reserved: assert property (p_cca_reserved) else $error("reserved mode clear"); // R8

    property p_flag_set;
        s.clear |=> s.flags[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("clear flag missed"); // R9

    sequence s_busy_tx_if_clear;
        wr_cmd && reg_wdata == rrcc_pkg::CMD_TX_IF_CLEAR && !s.clear
            && s.rstate == rrcc_pkg::RS_RX;
    endsequence
    property p_tx_if_clear_busy;
        s_busy_tx_if_clear |=> !antenna_switch_supply_pin;
    endproperty
    a_tx_if_clear_busy: assert property (p_tx_if_clear_busy) else $error("sent on busy"); // R10

    sequence s_rx_on_idle;
        wr_cmd && reg_wdata == rrcc_pkg::CMD_RX_ON && s.rstate == rrcc_pkg::RS_IDLE;
    endsequence
    property p_cal_on_rx;
        s_rx_on_idle |=> synth_calibrate [*3];
    endproperty
    a_cal_on_rx: assert property (p_cal_on_rx) else $error("no calibration"); // R14

    property p_lo_rx;
        s.rstate == rrcc_pkg::RS_RX
            |-> lo_channel_frequency_word_mhz == rrcc_pkg::BASE_CHANNEL_FREQUENCY_WORD_MHZ - rrcc_pkg::RX_IF_MHZ + {2'h0, s.channel_frequency_word};
    endproperty
    a_lo_rx: assert property (p_lo_rx) else $error("rx lo wrong"); // R11 R12

    property p_power;
        reg_wr && reg_addr == rrcc_pkg::ADDR_TX_POWER |=> pa_power_code == $past(reg_wdata);
    endproperty
    a_power: assert property (p_power) else $error("power code not applied"); // R15

    property p_switch;
        s.rstate == rrcc_pkg::RS_RX |-> !antenna_switch_supply_pin;
    endproperty
    a_switch: assert property (p_switch) else $error("switch high in rx"); // R16

    property p_append;
        frame_end && s.auto_checksum_enable |=> frame_append.valid && frame_append.crc_ok == $past(crc_ok);
    endproperty
    a_append: assert property (p_append) else $error("append missing"); // R4

    property p_dac;
        dac_override |-> s.rstate == rrcc_pkg::RS_TX && s.tx_mode == rrcc_pkg::TX_MODE_DAC_TEST;
    endproperty
    a_dac: assert property (p_dac) else $error("dac override wrong"); // R18

    // Conditional transmit on a clear channel: calibrate, switch and flag together
    sequence s_clear_tx_if_clear;
        wr_cmd && reg_wdata == rrcc_pkg::CMD_TX_IF_CLEAR && s.clear
            && s.rstate == rrcc_pkg::RS_RX;
    endsequence
    property p_tx_if_clear_go;
        s_clear_tx_if_clear |=> antenna_switch_supply_pin && synth_calibrate
            && s.flags[rrcc_pkg::FLAG_TX_START];
    endproperty
    a_tx_if_clear_go: assert property (p_tx_if_clear_go) else $error("tx not started"); // R10

    property p_lo_tx;
        s.rstate == rrcc_pkg::RS_TX |-> lo_channel_frequency_word_mhz == rrcc_pkg::BASE_CHANNEL_FREQUENCY_WORD_MHZ + {2'h0, s.channel_frequency_word};
    endproperty
    a_lo_tx: assert property (p_lo_tx) else $error("tx lo wrong"); // R11

    property p_tx_switch;
        is_tx(s.rstate) |-> antenna_switch_supply_pin;
    endproperty
    a_tx_switch: assert property (p_tx_switch) else $error("switch low in tx"); // R16

    // Append is a one-cycle pulse, so a consumer never counts one frame twice
    property p_append_once;
        !(frame_end && s.auto_checksum_enable) |=> !frame_append.valid;
    endproperty
    a_append_once: assert property (p_append_once) else $error("append pulse too long"); // R4
endmodule
`default_nettype wire

// ==== rrcc_radio_ctrl_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module rrcc_radio_ctrl_test;
    localparam int CAL = 4;
    localparam int SYM = rrcc_pkg::SYMBOL_CYCLES;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, energy_level = 8'hEC;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sfd_detect = 1'b0, corr_strobe = 1'b0;
    logic frame_active = 1'b0, frame_end = 1'b0, crc_ok = 1'b0, tx_done = 1'b0;
    logic [6:0] corr_sample = 7'h00;
    logic [7:0] reg_rdata, pa_power_code, gain_loop_low, gain_loop_high, rv;
    logic irq, antenna_switch_supply_pin, synth_calibrate, dac_override, e;
    logic [11:0] lo_channel_frequency_word_mhz;
    logic [15:0] dac_static_word;
    rrcc_pkg::rrcc_append_t frame_append;
    int fail_count = 0;
    int n_compared = 0;

    always #5 clk_sys = ~clk_sys;

    rrcc_radio_ctrl #(.CAL_CYCLES(CAL)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .energy_level(energy_level), .sfd_detect(sfd_detect), .corr_strobe(corr_strobe),
        .corr_sample(corr_sample), .frame_active(frame_active), .frame_end(frame_end),
        .crc_ok(crc_ok), .tx_done(tx_done), .irq(irq),
        .antenna_switch_supply_pin(antenna_switch_supply_pin),
        .synth_calibrate(synth_calibrate), .lo_channel_frequency_word_mhz(lo_channel_frequency_word_mhz),
        .pa_power_code(pa_power_code), .dac_override(dac_override),
        .dac_static_word(dac_static_word), .gain_loop_low(gain_loop_low),
        .gain_loop_high(gain_loop_high), .frame_append(frame_append)
    );

    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        chk(rv, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_cal;
        int i;
        for (i = 0; i < 100 && synth_calibrate !== 1'b0; i++) cyc(1);
        if (i == 100) begin
            fail_count++;
            results();
        end
    endtask

    task automatic pulse_cmd(input logic [7:0] c);
        wr(rrcc_pkg::ADDR_COMMAND, c);
        #1;
    endtask

    initial begin
        #1ms;
        fail_count++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1;
        chk(pa_power_code, 8'hFF);
        chk(lo_channel_frequency_word_mhz, 12'h7FE);
        chk({gain_loop_high, gain_loop_low}, 16'h0000);
        rchk(rrcc_pkg::ADDR_THRESH, 8'hE0);
        rchk(rrcc_pkg::ADDR_MODEM0_HIGH, 8'h02);
        rchk(rrcc_pkg::ADDR_MODEM0_LOW, 8'hC0);
        rchk(rrcc_pkg::ADDR_GAIN_LOW, 8'h00);
        rchk(8'h3F, 8'h00);
        $display("reset test done");
        // Channel 11 word, 357
        wr(rrcc_pkg::ADDR_SYNTH_HIGH, 8'h01);
        wr(rrcc_pkg::ADDR_SYNTH_LOW, 8'h65);
        wr(rrcc_pkg::ADDR_TX_POWER, 8'h03);
        cyc(2);
        chk(lo_channel_frequency_word_mhz, 12'h963);
        chk(pa_power_code, 8'h03);
        $display("frequency test done");
        pulse_cmd(rrcc_pkg::CMD_RX_ON);
        chk(synth_calibrate, 1'b1);
        chk(antenna_switch_supply_pin, 1'b0);
        wait_cal();
        chk(lo_channel_frequency_word_mhz, 12'h963);
        wr(rrcc_pkg::ADDR_THRESH, 8'h00);
        cyc(7 * SYM - 20);
        rchk(rrcc_pkg::ADDR_STATUS, 8'h00);
        // Seven samples of -20 and one empty slot: -17.5 floors to -18
        rchk(rrcc_pkg::ADDR_RSSI, 8'hEE);
        cyc(2 * SYM);
        rchk(rrcc_pkg::ADDR_STATUS, 8'h01);
        rchk(rrcc_pkg::ADDR_RSSI, 8'hEC);
        // Strength -20: equal threshold is busy, hysteresis holds busy until threshold minus 2 exceeds -20
        wr(rrcc_pkg::ADDR_THRESH, 8'hEC);
        cyc(3);
        rchk(rrcc_pkg::ADDR_STATUS, 8'h00);
        wr(rrcc_pkg::ADDR_THRESH, 8'hED);
        cyc(3);
        rchk(rrcc_pkg::ADDR_STATUS, 8'h00);
        wr(rrcc_pkg::ADDR_THRESH, 8'hF0);
        cyc(3);
        rchk(rrcc_pkg::ADDR_STATUS, 8'h01);
        $display("strength test done");
        for (int m = 0; m < 4; m++) begin
            for (int f = 0; f < 2; f++) begin
                @(posedge clk_sys) frame_active <= f[0];
                wr(rrcc_pkg::ADDR_MODEM0_LOW, {m[1:0], 6'h20});
                cyc(3);
                e = (m == 1) || (m >= 2 && f == 0);
                rchk(rrcc_pkg::ADDR_STATUS, {7'h00, e});
            end
        end
        @(posedge clk_sys) frame_active <= 1'b0;
        wr(rrcc_pkg::ADDR_MASK, 8'h01);
        cyc(3);
        chk(irq, 1'b1);
        wr(rrcc_pkg::ADDR_MODEM0_LOW, 8'h20);
        wr(rrcc_pkg::ADDR_FLAGS, 8'h0F);
        cyc(2);
        chk(irq, 1'b0);
        rchk(rrcc_pkg::ADDR_FLAGS, 8'h00);
        wr(rrcc_pkg::ADDR_MODEM0_LOW, 8'hE0);
        wr(rrcc_pkg::ADDR_MASK, 8'h00);
        cyc(3);
        chk(irq, 1'b0);
        rchk(rrcc_pkg::ADDR_FLAGS, 8'h01);
        $display("assessment test done");
        @(posedge clk_sys);
        sfd_detect <= 1'b1;
        @(posedge clk_sys);
        sfd_detect <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            corr_strobe <= 1'b1;
            corr_sample <= 7'h64 + i[6:0];
            @(posedge clk_sys);
            corr_strobe <= 1'b0;
        end
        cyc(2);
        rchk(rrcc_pkg::ADDR_CORR, 8'h67);
        rchk(rrcc_pkg::ADDR_FLAGS, 8'h03);
        @(posedge clk_sys);
        frame_end <= 1'b1;
        crc_ok <= 1'b1;
        @(posedge clk_sys);
        frame_end <= 1'b0;
        #1 chk(frame_append, {1'b1, 7'h67, 8'hEC, 1'b1});
        cyc(1);
        chk(frame_append.valid, 1'b0);
        $display("correlation test done");
        // Reserved mode 00 never reports clear: the conditional transmit must be dropped
        wr(rrcc_pkg::ADDR_MODEM0_LOW, 8'h20);
        cyc(3);
        pulse_cmd(rrcc_pkg::CMD_TX_IF_CLEAR);
        cyc(2);
        chk(antenna_switch_supply_pin, 1'b0);
        rchk(rrcc_pkg::ADDR_STATUS, 8'h00);
        wr(rrcc_pkg::ADDR_MODEM0_LOW, 8'h60);
        cyc(3);
        pulse_cmd(rrcc_pkg::CMD_TX_IF_CLEAR);
        chk(antenna_switch_supply_pin, 1'b1);
        chk(synth_calibrate, 1'b1);
        wait_cal();
        chk(lo_channel_frequency_word_mhz, 12'h965);
        rchk(rrcc_pkg::ADDR_STATUS, 8'h02);
        rchk(rrcc_pkg::ADDR_FLAGS, 8'h0F);
        @(posedge clk_sys);
        tx_done <= 1'b1;
        @(posedge clk_sys);
        tx_done <= 1'b0;
        cyc(1);
        chk(antenna_switch_supply_pin, 1'b0);
        chk(synth_calibrate, 1'b1);
        wait_cal();
        $display("conditional transmit test done");
        wr(rrcc_pkg::ADDR_MODEM1_LOW, 8'h08);
        wr(rrcc_pkg::ADDR_DAC_HIGH, 8'h18);
        wr(rrcc_pkg::ADDR_DAC_LOW, 8'h00);
        pulse_cmd(rrcc_pkg::CMD_TX_ON);
        wait_cal();
        cyc(1);
        chk(dac_override, 1'b1);
        chk(dac_static_word, 16'h1800);
        pulse_cmd(rrcc_pkg::CMD_RF_OFF);
        cyc(2);
        chk(dac_override, 1'b0);
        chk(antenna_switch_supply_pin, 1'b0);
        pulse_cmd(rrcc_pkg::CMD_RX_ON);
        wait_cal();
        pulse_cmd(rrcc_pkg::CMD_ACK);
        chk(synth_calibrate, 1'b1);
        chk(antenna_switch_supply_pin, 1'b1);
        $display("test mode and acknowledge test done");
        results();
    end
endmodule
`default_nettype wire
